// [common/crpc_pkg.sv]
// Package for the clock, reset and power-down controller: register map,
// field positions, reset values, timing figures and carrier types.
// Assumes a 125 MHz system clock standing in for the oscillator clock.
package crpc_pkg;

  localparam logic [7:0] SYS_CLK_CTRL_ADDR = 8'hd4;
  localparam logic [7:0] BT_CTRL_ADDR      = 8'hdc;
  localparam logic [7:0] PWR_STATUS_ADDR   = 8'hf0;

  localparam int WAKE_EN_BIT  = 7;
  localparam int DIV_HI_BIT   = 4;
  localparam int DIV_LO_BIT   = 3;

  // Bits 7, 6 and 2 read as one after reset, all others zero
  localparam logic [7:0] SYS_CLK_CTRL_RST = 8'hc4;
  localparam logic [7:0] SYS_CLK_CTRL_WMASK = 8'h98;
  localparam logic [7:0] BT_CTRL_RST      = 8'h00;
  localparam logic [3:0] WDT_DISABLE_KEY  = 4'ha;

  // Pin filter: extra samples a changed level must survive before it moves
  localparam logic [1:0] PIN_FILT_LAST    = 2'h3;
  localparam logic [3:0] DIV_CNT_WRAP     = 4'hf;
  localparam logic [1:0] OSC_OPT_RC       = 2'h0;

  localparam logic [1:0] DIV_16   = 2'h0;
  localparam logic [1:0] DIV_8    = 2'h1;
  localparam logic [1:0] DIV_2    = 2'h2;
  localparam logic [1:0] DIV_1    = 2'h3;

  localparam logic [7:0] OP_STOP  = 8'h7f;
  localparam logic [7:0] OP_IDLE  = 8'h6f;

  localparam logic [15:0] RESET_VECTOR = 16'h0100;

  localparam int OSC_PERIOD_PS   = 8000;
  // Stabilisation time in oscillator periods (two to the sixteenth)
  localparam int STAB_PERIODS    = 65536;
  localparam int STAB_CYCLES     = (STAB_PERIODS * OSC_PERIOD_PS + OSC_PERIOD_PS - 1)
                                   / OSC_PERIOD_PS;

  typedef enum logic [1:0] {
    CRPC_RUN,
    CRPC_IDLE,
    CRPC_STOP,
    CRPC_RESET
  } crpc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crpc_bus_req_t;

  typedef struct packed {
    logic stop_req;
    logic idle_req;
  } crpc_pd_req_t;

endpackage

// [hdl/crpc_top.sv]
// Clock, reset and power-down controller of a small microcontroller.
// Assumes all inputs synchronous to clk_i except the reset pin, which is
// synchronised here; the CPU decodes its opcode and presents it with a strobe.
// Registers: clock control, basic timer control and a read-only status word.
//
// Function
// - ROM option bits select RC or external oscillator
// - Internal oscillator frees crystal pins as I/O
// - Stop freezes oscillator, state kept
// - Stop ends on reset or filtered external irq
// - Idle gates CPU clock only
// - Idle ends on reset or any interrupt
// - Clock control register at D4H, read/write
// - Bits 4:3 select divide 1, 2, 8, 16
// - Bit 7 enables external irq stop wake
// - Reset: wake enabled, oscillator on, divide 16
// - ROM option picks low-voltage reset or pin
// - Four reset sources: power-on, pin, watchdog, low voltage
// - Reset pin filtered and synchronised to clock
// - Pin reset restores control registers to defaults
// - Watchdog overflow asserts internal reset
// - Low supply holds static reset
// - Key 1010B in timer control disables watchdog
// - Reset disables interrupts, enables watchdog, inputs ports
// - PC loads 0100H, fetch after stabilisation
// - Divide field 00B means divide 16
// - Interrupt wake keeps divide and control registers
// - Opcode 7FH enters stop, 6FH idle
`timescale 1ns/10ps
`default_nettype none

module crpc_top #(
  parameter int STAB_CYCLES_P = crpc_pkg::STAB_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire crpc_pkg::crpc_bus_req_t bus_i,
  output var  logic [7:0]             rdata_o,
  input  wire logic                   op_valid_i,
  input  wire logic [7:0]             opcode_i,
  input  wire logic [1:0]             osc_option_i,
  input  wire logic                   lvr_option_i,
  input  wire logic                   reset_pin_n_i,
  input  wire logic                   low_voltage_i,
  input  wire logic                   ext_irq_a_i,
  input  wire logic                   ext_irq_b_i,
  input  wire logic                   any_irq_i,
  input  wire logic                   bt_overflow_i,
  output var  logic                   osc_run_o,
  output var  logic                   cpu_clk_en_o,
  output var  logic                   periph_clk_en_o,
  output var  logic                   xtal_pins_gpio_o,
  output var  logic                   reset_shared_io_gpio_o,
  output var  logic                   sys_reset_o,
  output var  logic                   irq_disable_o,
  output var  logic                   ports_input_o,
  output var  logic                   wdt_enable_o,
  output var  logic                   pc_load_o,
  output var  logic [15:0]            pc_value_o,
  output var  logic                   fetch_start_o,
  output var  crpc_pkg::crpc_mode_t   mode_o
);

  logic [7:0]               clk_ctrl_q;
  logic [7:0]               bt_ctrl_q;
  logic                     wdt_en_q;
  logic                     pin_meta_q;
  logic                     pin_sync_q;
  logic                     pin_filt_q;
  logic [1:0]               filt_cnt_q;
  logic                     irq_a_q;
  logic                     irq_b_q;
  crpc_pkg::crpc_mode_t     mode_q;
  logic [31:0]              stab_cnt_q;
  logic [3:0]               div_cnt_q;
  logic [1:0]               div_sel_q;
  logic                     rst_src;
  logic                     pin_rst;
  logic                     lvr_rst;
  logic                     wdt_rst;
  logic                     wr_clk_ctrl;
  logic                     wr_bt_ctrl;
  logic                     ext_wake;
  logic                     tick;
  logic [31:0]              stab_limit;
  logic                     stab_done;

  // Divide setting to a mask on the free counter; a tick is one CPU enable
  function automatic logic [3:0] div_mask(input logic [1:0] sel);
    case (sel)
      crpc_pkg::DIV_1:  div_mask = 4'h0;
      crpc_pkg::DIV_2:  div_mask = 4'h1;
      crpc_pkg::DIV_8:  div_mask = 4'h7;
      default:          div_mask = 4'hf;
    endcase
  endfunction

  // Register decode shared by the write and read paths
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    reg_hit = (addr == reg_addr);
  endfunction

  // Pin sync; first stage read only by second
  always_ff @(posedge clk_i) begin
    pin_meta_q <= reset_pin_n_i;
    pin_sync_q <= pin_meta_q;
  end

  // Hysteresis stand-in: a new level must be seen four times before it moves
  // Starting low keeps reset asserted until the pin is actually seen high
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      filt_cnt_q <= 2'h0;
      pin_filt_q <= 1'b0;
    end else if (pin_sync_q == pin_filt_q) begin
      filt_cnt_q <= 2'h0;
    end else if (filt_cnt_q == crpc_pkg::PIN_FILT_LAST) begin
      filt_cnt_q <= 2'h0;
      pin_filt_q <= pin_sync_q;
    end else begin
      filt_cnt_q <= filt_cnt_q + 2'h1;
    end
  end

  // External irq noise filter: one registered sample stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_a_q <= ext_irq_a_i;
      irq_b_q <= ext_irq_b_i;
    end
  end

  // With the low-voltage option the pin is plain I/O and cannot reset
  assign pin_rst = !lvr_option_i && !pin_filt_q;
  assign lvr_rst = lvr_option_i && low_voltage_i;
  assign wdt_rst = wdt_en_q && bt_overflow_i;
  assign rst_src = sys_rst_i || pin_rst || lvr_rst || wdt_rst;

  assign wr_clk_ctrl = bus_i.wr && reg_hit(bus_i.addr, crpc_pkg::SYS_CLK_CTRL_ADDR);
  assign wr_bt_ctrl  = bus_i.wr && reg_hit(bus_i.addr, crpc_pkg::BT_CTRL_ADDR);

  // Wake bit gates only the filtered pins; idle also wakes on any_irq_i
  assign ext_wake = clk_ctrl_q[crpc_pkg::WAKE_EN_BIT] && (irq_a_q || irq_b_q);

  // Clock control register; a wake never touches it
  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      clk_ctrl_q <= crpc_pkg::SYS_CLK_CTRL_RST;
    end else if (wr_clk_ctrl) begin
      clk_ctrl_q <= (clk_ctrl_q & ~crpc_pkg::SYS_CLK_CTRL_WMASK)
                  | (bus_i.wdata & crpc_pkg::SYS_CLK_CTRL_WMASK);
    end
  end

  // Basic timer control: stabilisation select in bits 3:2, key in 7:4
  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      bt_ctrl_q <= crpc_pkg::BT_CTRL_RST;
    end else if (wr_bt_ctrl) begin
      bt_ctrl_q <= bus_i.wdata;
    end
  end

  // Any value other than the key turns the watchdog back on
  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      wdt_en_q <= 1'b1;
    end else if (wr_bt_ctrl) begin
      wdt_en_q <= (bus_i.wdata[7:4] != crpc_pkg::WDT_DISABLE_KEY);
    end
  end

  // Stabilisation length: full count, or scaled down by the timer setting
  always_comb begin
    if (mode_q == crpc_pkg::CRPC_RESET) begin
      stab_limit = 32'(STAB_CYCLES_P);
    end else begin
      stab_limit = 32'(STAB_CYCLES_P) >> bt_ctrl_q[3:2];
    end
  end

  assign stab_done = (stab_cnt_q >= stab_limit - 32'h1);

  // Power mode sequencer
  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      mode_q     <= crpc_pkg::CRPC_RESET;
      stab_cnt_q <= 32'h0;
    end else begin
      case (mode_q)
        crpc_pkg::CRPC_RESET: begin
          if (stab_done) begin
            mode_q     <= crpc_pkg::CRPC_RUN;
            stab_cnt_q <= 32'h0;
          end else begin
            stab_cnt_q <= stab_cnt_q + 32'h1;
          end
        end
        crpc_pkg::CRPC_RUN: begin
          // Opcodes are honoured only while the CPU is running
          if (op_valid_i && opcode_i == crpc_pkg::OP_STOP) begin
            mode_q <= crpc_pkg::CRPC_STOP;
          end else if (op_valid_i && opcode_i == crpc_pkg::OP_IDLE) begin
            mode_q <= crpc_pkg::CRPC_IDLE;
          end
        end
        crpc_pkg::CRPC_IDLE: begin
          // Wake leaves the divide field alone, so the CPU resumes at its old rate
          if (any_irq_i || ext_wake) begin
            mode_q <= crpc_pkg::CRPC_RUN;
          end
        end
        crpc_pkg::CRPC_STOP: begin
          // Counting here models oscillator restart delay after the wake
          if (stab_cnt_q != 32'h0) begin
            if (stab_cnt_q >= stab_limit) begin
              mode_q     <= crpc_pkg::CRPC_RUN;
              stab_cnt_q <= 32'h0;
            end else begin
              stab_cnt_q <= stab_cnt_q + 32'h1;
            end
          end else if (ext_wake) begin
            stab_cnt_q <= 32'h1;
          end
        end
        default: mode_q <= crpc_pkg::CRPC_RESET;
      endcase
    end
  end

  // Free divider; new setting is taken only at a full-period boundary
  assign tick = ((div_cnt_q & div_mask(div_sel_q)) == div_mask(div_sel_q));

  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      div_cnt_q <= 4'h0;
    end else if (mode_q != crpc_pkg::CRPC_STOP) begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  // Switching only at the wrap keeps every divided period whole
  always_ff @(posedge clk_i) begin
    if (rst_src) begin
      div_sel_q <= crpc_pkg::DIV_16;
    end else if (mode_q != crpc_pkg::CRPC_STOP && div_cnt_q == crpc_pkg::DIV_CNT_WRAP) begin
      div_sel_q <= clk_ctrl_q[crpc_pkg::DIV_HI_BIT:crpc_pkg::DIV_LO_BIT];
    end
  end

  // CPU clock runs only in run mode; idle leaves timer and interrupts clocked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_clk_en_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= tick && mode_q == crpc_pkg::CRPC_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_clk_en_o <= 1'b0;
    end else begin
      periph_clk_en_o <= tick && mode_q != crpc_pkg::CRPC_STOP
                              && mode_q != crpc_pkg::CRPC_RESET;
    end
  end

  // Oscillator is back on from the first cycle of a stop restart count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_run_o <= 1'b1;
    end else begin
      osc_run_o <= (mode_q != crpc_pkg::CRPC_STOP) || (stab_cnt_q != 32'h0);
    end
  end

  // Reset sequence outputs follow the internal reset one cycle late, irq disable until stabilisation ends
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sys_reset_o   <= 1'b1;
      irq_disable_o <= 1'b1;
      ports_input_o <= 1'b1;
    end else begin
      sys_reset_o   <= rst_src;
      irq_disable_o <= rst_src || mode_q == crpc_pkg::CRPC_RESET;
      ports_input_o <= rst_src;
    end
  end

  // Fetch pulses once, in the cycle after the stabilisation count runs out
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_load_o     <= 1'b0;
      fetch_start_o <= 1'b0;
    end else begin
      pc_load_o     <= rst_src;
      fetch_start_o <= !rst_src && mode_q == crpc_pkg::CRPC_RESET && stab_done;
    end
  end

  always_ff @(posedge clk_i) begin
    pc_value_o <= crpc_pkg::RESET_VECTOR;
  end

  // Option pins are static while running, so no reset is needed here
  always_ff @(posedge clk_i) begin
    xtal_pins_gpio_o       <= (osc_option_i == crpc_pkg::OSC_OPT_RC);
    reset_shared_io_gpio_o <= lvr_option_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wdt_enable_o <= 1'b1;
      mode_o       <= crpc_pkg::CRPC_RESET;
    end else begin
      wdt_enable_o <= wdt_en_q;
      mode_o       <= mode_q;
    end
  end

  // Read port: data in the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !bus_i.rd) begin
      rdata_o <= 8'h00;
    end else if (reg_hit(bus_i.addr, crpc_pkg::SYS_CLK_CTRL_ADDR)) begin
      rdata_o <= clk_ctrl_q;
    end else if (reg_hit(bus_i.addr, crpc_pkg::BT_CTRL_ADDR)) begin
      rdata_o <= bt_ctrl_q;
    end else if (reg_hit(bus_i.addr, crpc_pkg::PWR_STATUS_ADDR)) begin
      rdata_o <= {4'h0, wdt_en_q, pin_filt_q, mode_q};
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [testbench/clock_reset_power_control_bench.sv]
// Self-checking bench for crpc_top with the far-side model.
// Assumes a 125 MHz clock and a shortened stabilisation count.
`timescale 1ns/10ps
`default_nettype none
module clock_reset_power_control_bench;
  logic clk_i = 0, sys_rst_i = 1, op_valid_i = 0, lvr_option_i = 0, low_voltage_i = 0;
  logic any_irq_i = 0, bt_overflow_i = 0, pin_req = 0, reset_pin_n_i, ext_irq_a_i;
  logic ext_irq_b_i, osc_run_o, cpu_clk_en_o, periph_clk_en_o, xtal_pins_gpio_o;
  logic reset_shared_io_gpio_o, sys_reset_o, irq_disable_o, ports_input_o, wdt_enable_o;
  logic pc_load_o, fetch_start_o;
  logic [1:0] osc_option_i = 2'h1, irq_req = 2'h0;
  logic [7:0] opcode_i = 8'h00, rdata_o, d;
  logic [15:0] pc_value_o;
  crpc_pkg::crpc_bus_req_t bus_i = '0;
  crpc_pkg::crpc_mode_t mode_o;
  int bad_count = 0, checks = 0, seed = 32'hd7c9cbb9, n, p;
  crpc_top #(.STAB_CYCLES_P(64)) dut (.clk_i, .sys_rst_i, .bus_i, .rdata_o, .op_valid_i,
    .opcode_i, .osc_option_i, .lvr_option_i, .reset_pin_n_i, .low_voltage_i, .ext_irq_a_i,
    .ext_irq_b_i, .any_irq_i, .bt_overflow_i, .osc_run_o, .cpu_clk_en_o, .periph_clk_en_o,
    .xtal_pins_gpio_o, .reset_shared_io_gpio_o, .sys_reset_o, .irq_disable_o,
    .ports_input_o, .wdt_enable_o, .pc_load_o, .pc_value_o, .fetch_start_o, .mode_o);
  crpc_ext_model ext (.clk_i, .pin_req_i(pin_req), .irq_req_i(irq_req),
    .reset_pin_n_o(reset_pin_n_i), .ext_irq_a_o(ext_irq_a_i), .ext_irq_b_o(ext_irq_b_i));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i) bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_i) bus_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i) bus_i <= '0;
    #1 chk("rdata", {8'h00, rdata_o}, {8'h00, exp});
  endtask
  task automatic op(input logic [7:0] c);
    @(posedge clk_i) op_valid_i <= 1'b1;
    opcode_i <= c;
    @(posedge clk_i) op_valid_i <= 1'b0;
  endtask
  task automatic wait_mode(input crpc_pkg::crpc_mode_t m, input int lim);
    #1;
    for (int i = 0; i < lim && mode_o !== m; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("mode", 16'(mode_o), 16'(m));
  endtask
  task automatic count();
    n = 0;
    p = 0;
    repeat (64) begin
      @(posedge clk_i);
      #1 n += int'(cpu_clk_en_o === 1'b1);
      p += int'(periph_clk_en_o === 1'b1);
    end
  endtask
  task automatic bt_pulse();
    @(posedge clk_i) bt_overflow_i <= 1'b1;
    @(posedge clk_i) bt_overflow_i <= 1'b0;
  endtask
  function automatic int rate(input int c);
    return c == 0 ? 16 : c == 1 ? 8 : c == 2 ? 2 : 1;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wait_mode(crpc_pkg::CRPC_RUN, 200);
    chk("xtal", 16'(xtal_pins_gpio_o), 16'h0000);
    chk("wdt", 16'(wdt_enable_o), 16'h0001);
    rd(8'hd4, 8'hc4);
    rd(8'h33, 8'h00);
    // Only the wake bit and the divide field take writes
    repeat (8) begin
      d = 8'($random(seed));
      wr(8'hd4, d);
      rd(8'hd4, (d & 8'h98) | 8'h44);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'hd4, 8'h80 | 8'(c << 3));
      repeat (40) @(posedge clk_i);
      count();
      chk("cpu rate", 16'(n), 16'(64 / rate(c)));
    end
    $display("register test done");
    wr(8'hdc, 8'h00);
    wr(8'hd4, 8'h18);
    op(8'h7f);
    wait_mode(crpc_pkg::CRPC_STOP, 2);
    chk("osc", 16'(osc_run_o), 16'h0000);
    @(posedge clk_i) irq_req <= 2'h1;
    repeat (100) @(posedge clk_i);
    wait_mode(crpc_pkg::CRPC_STOP, 0);
    @(posedge clk_i) irq_req <= 2'h0;
    pin_req <= 1'b1;
    @(posedge clk_i) pin_req <= 1'b0;
    wait_mode(crpc_pkg::CRPC_RESET, 20);
    wait_mode(crpc_pkg::CRPC_RUN, 200);
    rd(8'hd4, 8'hc4);
    wr(8'hd4, 8'h90);
    op(8'h7f);
    wait_mode(crpc_pkg::CRPC_STOP, 2);
    @(posedge clk_i) irq_req <= 2'h2;
    wait_mode(crpc_pkg::CRPC_RUN, 200);
    @(posedge clk_i) irq_req <= 2'h0;
    rd(8'hd4, 8'hd4);
    op(8'h6f);
    wait_mode(crpc_pkg::CRPC_IDLE, 2);
    count();
    chk("idle cpu", 16'(n), 16'h0000);
    chk("idle timer", 16'(p > 0), 16'h0001);
    @(posedge clk_i) any_irq_i <= 1'b1;
    wait_mode(crpc_pkg::CRPC_RUN, 3);
    @(posedge clk_i) any_irq_i <= 1'b0;
    rd(8'hd4, 8'hd4);
    $display("power-down test done");
    bt_pulse();
    wait_mode(crpc_pkg::CRPC_RESET, 4);
    wait_mode(crpc_pkg::CRPC_RUN, 200);
    wr(8'hdc, 8'ha0);
    rd(8'hdc, 8'ha0);
    bt_pulse();
    repeat (10) @(posedge clk_i);
    wait_mode(crpc_pkg::CRPC_RUN, 0);
    chk("wdt off", 16'(wdt_enable_o), 16'h0000);
    rd(8'hf0, 8'h04);
    @(posedge clk_i) lvr_option_i <= 1'b1;
    low_voltage_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    #1 chk("lvr", 16'(sys_reset_o), 16'h0001);
    chk("pin io", 16'(reset_shared_io_gpio_o), 16'h0001);
    @(posedge clk_i) low_voltage_i <= 1'b0;
    wait_mode(crpc_pkg::CRPC_RUN, 200);
    @(posedge clk_i) pin_req <= 1'b1;
    @(posedge clk_i) pin_req <= 1'b0;
    repeat (20) @(posedge clk_i);
    wait_mode(crpc_pkg::CRPC_RUN, 0);
    @(posedge clk_i) osc_option_i <= 2'h0;
    repeat (3) @(posedge clk_i);
    #1 chk("xtal io", 16'(xtal_pins_gpio_o), 16'h0001);
    $display("reset source test done");
    results();
  end
endmodule
`default_nettype wire

// [testbench/crpc_ext_model.sv]
// Far side: reset pin circuit and the two filtered external irq lines.
// Assumes requests change just after a rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module crpc_ext_model #(
  parameter int HOLD_P = 8
) (
  input  wire logic       clk_i,
  input  wire logic       pin_req_i,
  input  wire logic [1:0] irq_req_i,
  output logic            reset_pin_n_o,
  output logic            ext_irq_a_o,
  output logic            ext_irq_b_o
);
  int hold_q = 0;
  // Short requests are stretched so the pin stays low long enough to settle
  always_ff @(posedge clk_i) begin
    hold_q <= pin_req_i ? HOLD_P : (hold_q > 0 ? hold_q - 1 : 0);
  end
  assign reset_pin_n_o = !(pin_req_i || hold_q > 0);
  assign ext_irq_a_o = irq_req_i[0];
  assign ext_irq_b_o = irq_req_i[1];
endmodule
`default_nettype wire

// [testbench/crpc_properties.sv]
// Port-level timing checks for crpc_top.
// Assumes it is bound into crpc_top; everything runs on clk_i.
`timescale 1ns/10ps
`default_nettype none
module crpc_properties #(
  parameter int STAB_CYCLES_P = 64
) (
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 op_valid_i,
  input wire logic [7:0]           opcode_i,
  input wire logic [1:0]           osc_option_i,
  input wire logic                 lvr_option_i,
  input wire logic                 low_voltage_i,
  input wire logic                 any_irq_i,
  input wire logic                 osc_run_o,
  input wire logic                 cpu_clk_en_o,
  input wire logic                 periph_clk_en_o,
  input wire logic                 xtal_pins_gpio_o,
  input wire logic                 sys_reset_o,
  input wire logic                 irq_disable_o,
  input wire logic                 ports_input_o,
  input wire logic                 pc_load_o,
  input wire logic [15:0]          pc_value_o,
  input wire logic                 fetch_start_o,
  input wire crpc_pkg::crpc_mode_t mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  stop_freeze_a: assert property (mode_o == crpc_pkg::CRPC_STOP |->
    !cpu_clk_en_o && !periph_clk_en_o) else $error("clock running in stop");
  stop_osc_a: assert property ($rose(mode_o == crpc_pkg::CRPC_STOP) |->
    !osc_run_o) else $error("oscillator running in stop");
  idle_gate_a: assert property (mode_o == crpc_pkg::CRPC_IDLE |->
    !cpu_clk_en_o) else $error("cpu clock running in idle");
  idle_wake_a: assert property (mode_o == crpc_pkg::CRPC_IDLE && any_irq_i |->
    ##[1:2] mode_o == crpc_pkg::CRPC_RUN) else $error("idle not left on interrupt");
  stop_entry_a: assert property (op_valid_i && opcode_i == crpc_pkg::OP_STOP &&
    mode_o == crpc_pkg::CRPC_RUN |-> ##2 mode_o == crpc_pkg::CRPC_STOP)
    else $error("no stop");
  xtal_gpio_a: assert property ($stable(osc_option_i)[*3] |->
    xtal_pins_gpio_o == (osc_option_i == 2'h0)) else $error("crystal pin mode wrong");
  lvr_hold_a: assert property (lvr_option_i && low_voltage_i |->
    ##[1:3] sys_reset_o) else $error("low supply without reset");
  reset_outs_a: assert property (sys_reset_o |->
    irq_disable_o && ports_input_o) else $error("reset outputs wrong");
  pc_vector_a: assert property (pc_load_o |->
    pc_value_o == 16'h0100) else $error("reset vector wrong");
  fetch_once_a: assert property (fetch_start_o |=>
    !fetch_start_o && mode_o == crpc_pkg::CRPC_RUN) else $error("fetch pulse wrong");
endmodule
bind crpc_top crpc_properties #(.STAB_CYCLES_P(STAB_CYCLES_P)) u_props (
  .clk_i, .sys_rst_i, .op_valid_i, .opcode_i, .osc_option_i, .lvr_option_i,
  .low_voltage_i, .any_irq_i, .osc_run_o, .cpu_clk_en_o, .periph_clk_en_o, .xtal_pins_gpio_o,
  .sys_reset_o, .irq_disable_o, .ports_input_o, .pc_load_o, .pc_value_o,
  .fetch_start_o, .mode_o);
`default_nettype wire
